// ### include/rljc_pkg.sv
// constants and types for the rotary limit and jog controller
package rljc_pkg;
    // position unit is 0.001 degree
    localparam int POS_W = 20;
    localparam int SET_W = 21;
    localparam logic [POS_W-1:0] FULL_TURN = 20'h57e40;
    localparam logic [POS_W-1:0] POS_RESET = 20'h00000;
    localparam int SPD_W = 16;
    localparam logic [SPD_W-1:0] SPD_ZERO = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [1:0] MULT_X1 = 2'h0;
    localparam logic [1:0] MULT_X10 = 2'h1;
    localparam logic [1:0] MULT_X100 = 2'h2;
    localparam logic [7:0] FACT_X1 = 8'h01;
    localparam logic [7:0] FACT_X10 = 8'h0a;
    localparam logic [7:0] FACT_X100 = 8'h64;
    localparam logic [1:0] QUAD_FWD_STEP = 2'h1;
    localparam logic [1:0] QUAD_REV_STEP = 2'h2;

    typedef enum logic [1:0] {
        RLJC_IDLE = 2'b00,
        RLJC_JOG_CCW = 2'b01,
        RLJC_JOG_CW = 2'b10
    } rljc_state_t;
endpackage : rljc_pkg

// ### logic/rljc_wrap.sv
// converts a signed degree setting into the 0..359.999 ring
`timescale 1ns/1ps
`default_nettype none
module rljc_wrap
    import rljc_pkg::*;
(
    input wire logic [rljc_pkg::SET_W-1:0] set_in,
    output logic [rljc_pkg::POS_W-1:0] ring_out
);
    logic signed [SET_W:0] full_s;
    logic signed [SET_W:0] v;
    logic signed [SET_W:0] q;
    always_comb
    begin
        full_s = $signed({2'b00, FULL_TURN});
        v = $signed({set_in[SET_W-1], set_in});
        q = v / full_s;
        ring_out = v[POS_W-1:0];
        if (v >= full_s)
        begin
            ring_out = POS_W'(v % full_s);
        end
        else if (v < 0 && v > -full_s)
        begin
            ring_out = POS_W'(v + full_s);
        end
        else if (v < 0)
        begin
            // quotient form kept as specified for large negatives
            ring_out = POS_W'(full_s + q);
        end
    end
endmodule : rljc_wrap
`default_nettype wire

// ### logic/rljc_top.sv
// rotary limit, range output, jog and handwheel control
// Overview of operation
// - positions wrap as a ring address
// - limit settings kept within 0..359.999
// - settings above 360 taken modulo 360
// - small negative settings get 360 added
// - large negatives become 360 plus quotient
// - motion allowed only on ccw arc
// - equal limits disable the limit check
// - range addresses kept within 0..359.999
// - range window is ccw arc minus-to-plus
// - manual mode when mode input off
// - forward start jogs at jog speed
// - direction parameter swaps ccw and cw
// - reverse start jogs opposite direction
// - both or neither start stops jog
// - handwheel counts scaled by multiplier
// - multiplier inputs override the parameter
// - parameter codes 0,1,2 give 1,10,100
// - handwheel direction follows direction parameter
// - handwheel adds to jog motion
`timescale 1ns/1ps
`default_nettype none
module rljc_top
    import rljc_pkg::*;
#(
    parameter int ACC_W = 8
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic op_mode_select,
    input wire logic fwd_start_in,
    input wire logic rev_start_in,
    input wire logic [4:0] table_select_in,
    input wire logic mult_sel_low,
    input wire logic mult_sel_high,
    input wire logic rotation_direction_param,
    input wire logic [1:0] handwheel_mult_param,
    input wire logic [rljc_pkg::SPD_W-1:0] jog_speed_param,
    input wire logic [ACC_W-1:0] jog_accel_step,
    input wire logic [rljc_pkg::SET_W-1:0] soft_limit_plus,
    input wire logic [rljc_pkg::SET_W-1:0] soft_limit_minus,
    input wire logic [rljc_pkg::SET_W-1:0] range_out_plus,
    input wire logic [rljc_pkg::SET_W-1:0] range_out_minus,
    input wire logic hw_phase_a,
    input wire logic hw_phase_b,
    output logic [rljc_pkg::POS_W-1:0] cmd_pos,
    output logic [rljc_pkg::POS_W-1:0] cur_pos,
    output logic [rljc_pkg::SPD_W-1:0] jog_speed_out,
    output logic motor_ccw,
    output logic motor_cw,
    output logic manual_mode,
    output logic limit_hit,
    output logic range_out_flag
);
    import rljc_pkg::*;

    typedef struct packed {
        rljc_state_t st;
        logic [POS_W-1:0] cmd;
        logic [POS_W-1:0] cur;
        logic [SPD_W-1:0] spd;
        logic [ACC_W-1:0] acc;
        logic [1:0] ab;
        logic ccw;
        logic cw;
        logic manual;
        logic lim;
        logic rng;
    } rljc_regs_t;

    rljc_regs_t s_reg;
    rljc_regs_t s_next;

    logic [POS_W-1:0] lim_p;
    logic [POS_W-1:0] lim_m;
    logic [POS_W-1:0] rng_p;
    logic [POS_W-1:0] rng_m;

    // all four settings folded into the ring before any comparison
    rljc_wrap u_wlp (.set_in(soft_limit_plus), .ring_out(lim_p));
    rljc_wrap u_wlm (.set_in(soft_limit_minus), .ring_out(lim_m));
    rljc_wrap u_wrp (.set_in(range_out_plus), .ring_out(rng_p));
    rljc_wrap u_wrm (.set_in(range_out_minus), .ring_out(rng_m));

    function automatic logic on_arc(
        input logic [POS_W-1:0] p,
        input logic [POS_W-1:0] start,
        input logic [POS_W-1:0] stop
    );
        // ccw arc from start to stop, may straddle zero
        if (start <= stop)
            return (p >= start) && (p <= stop);
        else
            return (p >= start) || (p <= stop);
    endfunction : on_arc

    function automatic logic [POS_W-1:0] ring_step(
        input logic [POS_W-1:0] p,
        input logic [POS_W-1:0] d,
        input logic up
    );
        logic [POS_W:0] t;
        t = '0;
        if (up)
        begin
            t = {1'b0, p} + {1'b0, d};
            if (t >= {1'b0, FULL_TURN})
                t = t - {1'b0, FULL_TURN};
        end
        else
        begin
            t = {1'b0, p} + {1'b0, FULL_TURN} - {1'b0, d};
            if (t >= {1'b0, FULL_TURN})
                t = t - {1'b0, FULL_TURN};
        end
        return t[POS_W-1:0];
    endfunction : ring_step

    logic [7:0] hw_fact;
    logic hw_fwd;
    logic hw_rev;
    logic jog_want;
    logic jog_dir_ccw;
    logic hw_ccw;
    logic lim_on;
    logic [POS_W-1:0] cand;
    logic [POS_W-1:0] jog_d;
    logic move;
    logic move_ccw;
    logic [POS_W-1:0] move_d;

    always_comb
    begin
        unique case ({mult_sel_high, mult_sel_low})
            2'b01: hw_fact = FACT_X1;
            2'b10: hw_fact = FACT_X10;
            2'b11: hw_fact = FACT_X100;
            default:
            begin
                // parameter codes, unknown code falls back to x1
                if (handwheel_mult_param == MULT_X10)
                    hw_fact = FACT_X10;
                else if (handwheel_mult_param == MULT_X100)
                    hw_fact = FACT_X100;
                else
                    hw_fact = FACT_X1;
            end
        endcase
    end

    always_comb
    begin
        s_next = s_reg;
        // table select input not used in any mode
        s_next.manual = !op_mode_select;
        s_next.ab = {hw_phase_a, hw_phase_b};
        // one count per quadrature edge; direction by gray step
        hw_fwd = 1'b0;
        hw_rev = 1'b0;
        if (!op_mode_select && s_reg.ab != {hw_phase_a, hw_phase_b})
        begin
            // a leads b: old a equals new b on every forward step
            hw_fwd = (s_reg.ab[1] == hw_phase_b);
            hw_rev = !hw_fwd;
        end
        jog_want = !op_mode_select && (fwd_start_in ^ rev_start_in);
        jog_dir_ccw = fwd_start_in ^ rotation_direction_param;
        hw_ccw = hw_fwd ^ rotation_direction_param;
        lim_on = (lim_p != lim_m);

        unique case (s_reg.st)
            RLJC_IDLE:
            begin
                if (jog_want)
                    s_next.st = jog_dir_ccw ? RLJC_JOG_CCW : RLJC_JOG_CW;
            end
            RLJC_JOG_CCW, RLJC_JOG_CW:
            begin
                if (!jog_want)
                    s_next.st = RLJC_IDLE;
                else
                    s_next.st = jog_dir_ccw ? RLJC_JOG_CCW : RLJC_JOG_CW;
            end
            default: s_next.st = RLJC_IDLE;
        endcase

        // simple ramp toward jog speed, one unit per cycle
        if (s_reg.st != RLJC_IDLE && s_next.st == s_reg.st)
        begin
            if (s_reg.spd < jog_speed_param)
                s_next.spd = s_reg.spd + 1'b1;
            else
                s_next.spd = jog_speed_param;
        end
        else
            s_next.spd = SPD_ZERO;
        s_next.acc = s_reg.acc + jog_accel_step;

        // position advances by the current speed on each accumulator wrap
        jog_d = (s_reg.st != RLJC_IDLE && s_reg.spd != SPD_ZERO
                 && s_next.acc < s_reg.acc) ? POS_W'(s_reg.spd) : '0;
        move = 1'b0;
        move_ccw = 1'b1;
        move_d = '0;
        // handwheel merged on top of jog motion
        if (hw_fwd || hw_rev)
        begin
            move = 1'b1;
            move_ccw = hw_ccw;
            move_d = POS_W'(hw_fact);
            if (jog_d != '0)
            begin
                if (hw_ccw == (s_reg.st == RLJC_JOG_CCW))
                    move_d = move_d + jog_d;
                else if (jog_d >= move_d)
                begin
                    move_d = jog_d - move_d;
                    move_ccw = (s_reg.st == RLJC_JOG_CCW);
                end
                else
                    move_d = move_d - jog_d;
            end
        end
        else if (jog_d != '0)
        begin
            move = 1'b1;
            move_ccw = (s_reg.st == RLJC_JOG_CCW);
            move_d = jog_d;
        end

        cand = ring_step(s_reg.cmd, move_d, move_ccw);
        s_next.lim = 1'b0;
        if (move)
        begin
            // target outside ccw arc minus-to-plus is refused
            if (lim_on && !on_arc(cand, lim_m, lim_p))
                s_next.lim = 1'b1;
            else
                s_next.cmd = cand;
        end
        // cur follows the command one cycle later
        s_next.cur = s_reg.cmd;
        if (s_next.lim)
            s_next.spd = SPD_ZERO;
        s_next.ccw = (s_next.st == RLJC_JOG_CCW) && !s_next.lim;
        s_next.cw = (s_next.st == RLJC_JOG_CW) && !s_next.lim;
        s_next.rng = on_arc(s_reg.cur, rng_m, rng_p);
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_reg.st <= RLJC_IDLE;
            s_reg.cmd <= POS_RESET;
            s_reg.cur <= POS_RESET;
            s_reg.spd <= SPD_ZERO;
            s_reg.acc <= ACC_W'(ACC_RESET);
            // take the idle phase so release gives no false count
            s_reg.ab <= {hw_phase_a, hw_phase_b};
            s_reg.ccw <= 1'b0;
            s_reg.cw <= 1'b0;
            s_reg.manual <= 1'b0;
            s_reg.lim <= 1'b0;
            s_reg.rng <= 1'b0;
        end
        else
            s_reg <= s_next;
    end

    assign cmd_pos = s_reg.cmd;
    assign cur_pos = s_reg.cur;
    assign jog_speed_out = s_reg.spd;
    assign motor_ccw = s_reg.ccw;
    assign motor_cw = s_reg.cw;
    assign manual_mode = s_reg.manual;
    assign limit_hit = s_reg.lim;
    assign range_out_flag = s_reg.rng;
endmodule : rljc_top
`default_nettype wire

// ### verif/rljc_monitor.sv
// port assertions for the rotary limit and jog controller
`timescale 1ns/1ps
`default_nettype none
module rljc_monitor
    import rljc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic op_mode_select,
    input wire logic fwd_start_in,
    input wire logic rev_start_in,
    input wire logic rotation_direction_param,
    input wire logic [rljc_pkg::SET_W-1:0] soft_limit_plus,
    input wire logic [rljc_pkg::SET_W-1:0] soft_limit_minus,
    input wire logic [rljc_pkg::POS_W-1:0] cmd_pos,
    input wire logic [rljc_pkg::POS_W-1:0] cur_pos,
    input wire logic motor_ccw,
    input wire logic motor_cw,
    input wire logic manual_mode,
    input wire logic limit_hit,
    input wire logic range_out_flag
);
    import rljc_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    wire logic lim_off = soft_limit_plus == soft_limit_minus;
    wire logic man_in = !op_mode_select;
    property p_mode; 1 |=> manual_mode == !$past(op_mode_select);
    endproperty
    a_mode: assert property (p_mode) else $error("manual mode wrong");
    property p_auto; op_mode_select |=> !motor_ccw && !motor_cw;
    endproperty
    a_auto: assert property (p_auto) else $error("jog in auto");
    property p_fwd; man_in && fwd_start_in && !rev_start_in && lim_off
        |=> motor_cw == $past(rotation_direction_param)
        && motor_ccw != $past(rotation_direction_param);
    endproperty
    a_fwd: assert property (p_fwd) else $error("fwd dir wrong");
    property p_rev; man_in && rev_start_in && !fwd_start_in && lim_off
        |=> motor_ccw == $past(rotation_direction_param)
        && motor_cw != $past(rotation_direction_param);
    endproperty
    a_rev: assert property (p_rev) else $error("rev dir wrong");
    property p_stop; fwd_start_in == rev_start_in |=> !motor_ccw && !motor_cw;
    endproperty
    a_stop: assert property (p_stop) else $error("jog not stopped");
    property p_ring; 1 |-> cmd_pos < FULL_TURN && cur_pos < FULL_TURN;
    endproperty
    a_ring: assert property (p_ring) else $error("position off ring");
    property p_cur; 1 |=> cur_pos == $past(cmd_pos);
    endproperty
    a_cur: assert property (p_cur) else $error("cur not following");
    property p_nolim; lim_off [*2] |-> !limit_hit;
    endproperty
    a_nolim: assert property (p_nolim) else $error("limit while off");
    c_ccw: cover property (motor_ccw);
    c_hit: cover property (limit_hit);
    c_rng: cover property (range_out_flag);
endmodule : rljc_monitor
bind rljc_top rljc_monitor u_mon (.mclk, .srst, .op_mode_select,
    .fwd_start_in, .rev_start_in, .rotation_direction_param,
    .soft_limit_plus, .soft_limit_minus, .cmd_pos, .cur_pos, .motor_ccw,
    .motor_cw, .manual_mode, .limit_hit, .range_out_flag);
`default_nettype wire

// ### verif/rljc_hw_model.sv
// handwheel quadrature source with the host's pulse input setup
`timescale 1ns/1ps
`default_nettype none
module rljc_hw_model #(
    parameter int FORM_CODE = 2,
    parameter int FILTER_CODE = 2
)
(
    input wire logic mclk,
    input wire logic step_fwd,
    input wire logic step_rev,
    output logic hw_phase_a,
    output logic hw_phase_b
);
    // idle phase at power-on; the device learns it during reset
    logic [1:0] ph_reg = 2'h0;
    // a leads b going forward: 00 10 11 01
    assign hw_phase_a = ph_reg[1] ^ ph_reg[0];
    assign hw_phase_b = ph_reg[1];
    always @(posedge mclk)
    begin
        if (step_fwd)
            ph_reg <= ph_reg + 2'h1;
        else if (step_rev)
            ph_reg <= ph_reg - 2'h1;
    end
endmodule : rljc_hw_model
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the rotary limit and jog controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rljc_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, md = 1'b1, fw = 1'b0, rv = 1'b0;
    logic lo = 1'b0, hi = 1'b0, dir = 1'b0, sf = 1'b0, sr = 1'b0;
    logic [4:0] tsel = 5'h00;
    logic [1:0] prm = 2'h0;
    logic [SET_W-1:0] lp = 21'h000000, lm = 21'h000000;
    logic [SET_W-1:0] rp = 21'h000000, rm = 21'h000000;
    logic [15:0] spd_prm = 16'h0010;
    logic [15:0] spd;
    logic pa, pb, ccw, cw, man, hit, rflag;
    logic [POS_W-1:0] cmd, cur;
    int error_cnt = 0, samples_checked = 0, i, pos;
    always #4 mclk = ~mclk;
    rljc_hw_model hw (.mclk(mclk), .step_fwd(sf), .step_rev(sr),
        .hw_phase_a(pa), .hw_phase_b(pb));
    rljc_top dut (.mclk(mclk), .srst(srst), .op_mode_select(md),
        .fwd_start_in(fw), .rev_start_in(rv), .table_select_in(tsel),
        .mult_sel_low(lo), .mult_sel_high(hi),
        .rotation_direction_param(dir), .handwheel_mult_param(prm),
        .jog_speed_param(spd_prm), .jog_accel_step(8'h80),
        .soft_limit_plus(lp), .soft_limit_minus(lm), .range_out_plus(rp),
        .range_out_minus(rm), .hw_phase_a(pa), .hw_phase_b(pb),
        .cmd_pos(cmd), .cur_pos(cur), .jog_speed_out(spd),
        .motor_ccw(ccw), .motor_cw(cw), .manual_mode(man),
        .limit_hit(hit), .range_out_flag(rflag));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    function automatic int ring(input int v);
        if (v >= 360000)
            return v % 360000;
        if (v > -360000 && v < 0)
            return v + 360000;
        if (v <= -360000)
            return 360000 + v / 360000;
        return v;
    endfunction : ring
    function automatic logic in_arc(input int p, input int s, input int e);
        return (s <= e) ? (p >= s && p <= e) : (p >= s || p <= e);
    endfunction : in_arc
    // md fw rv dir : ccw cw
    logic [5:0] jog_rows [7] = '{6'b010010, 6'b010101, 6'b001001,
        6'b001110, 6'b011000, 6'b000100, 6'b110000};
    // lo hi prm dir, signed step
    int hw_rows [7][5] = '{'{0, 0, 0, 1, -1}, '{0, 0, 0, 0, 1},
        '{0, 0, 1, 0, 10}, '{0, 0, 2, 0, 100}, '{1, 0, 2, 0, 1},
        '{0, 1, 0, 0, 10}, '{1, 1, 0, 0, 100}};
    int rng_rows [7][2] = '{'{0, 300}, '{300, 0}, '{-100, 500},
        '{360300, 360100}, '{-400000, 250}, '{200, 720221},
        '{222, 359999}};
    initial
    begin
        tick(1);
        chk("manual_rst", 0, man);
        tick(4);
        srst = 1'b0;
        for (i = 0; i < 7; i++)
        begin
            {md, fw, rv, dir} = jog_rows[i][5:2];
            tsel = 5'(i * 5);
            tick(2);
            chk("motor_ccw", jog_rows[i][1], ccw);
            chk("motor_cw", jog_rows[i][0], cw);
            chk("manual", !md, man);
        end
        {md, fw, rv, srst} = 4'b0001;
        tick(5);
        chk("cmd_rst", 0, cmd);
        srst = 1'b0;
        pos = 0;
        for (i = 0; i < 7; i++)
        begin
            {lo, hi, dir} = {hw_rows[i][0][0], hw_rows[i][1][0],
                hw_rows[i][3][0]};
            prm = 2'(hw_rows[i][2]);
            tick(1);
            sf = 1'b1;
            tick(1);
            sf = 1'b0;
            tick(4);
            pos = ring(pos + hw_rows[i][4]);
            chk("cmd_pos", pos, cmd);
        end
        for (i = 0; i < 7; i++)
        begin
            rm = rng_rows[i][0][20:0];
            rp = rng_rows[i][1][20:0];
            tick(4);
            chk("range_flag", in_arc(pos, ring(rng_rows[i][0]),
                ring(rng_rows[i][1])), rflag);
        end
        lm = 21'(pos);
        lp = 21'h0003e8;
        {dir, rv} = 2'b01;
        for (i = 0; i < 3000 && hit !== 1'b1; i++)
            tick(1);
        chk("limit_hit", 1, hit);
        tick(3);
        chk("cmd_held", pos, cmd);
        {rv, fw, lp} = {2'b01, lm};
        for (i = 0; i < 500 && spd !== spd_prm; i++)
            tick(1);
        chk("jog_speed", spd_prm, spd);
        chk("form_code", 2, hw.FORM_CODE);
        chk("filter_code", 1, hw.FILTER_CODE > 1);
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
